// ### rtl/pocr_top.sv
// Over-current routing register bank for a four-port hub, Avalon-MM slave.
// Assumes byte addressing, 8-bit registers in the low lane, inputs synchronous to clk.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pocr_regs.svh"
module pocr_top #(
    parameter int ADDR_W = 17
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] overcurrent_sense,
    input wire logic [3:0] gpio_sense,
    input wire logic port1_overcurrent,
    input wire logic [3:0] charge_handshake_det,
    output logic [3:0] port_overcurrent,
    output logic gang_overcurrent,
    output logic [15:0] gang_pin_oe,
    output logic irq
);
    // Register index must fit above the two byte-offset bits; a wider bus would alias registers
    if (ADDR_W < 17 || ADDR_W > 18) begin : g_addr_w_check
        $error("ADDR_W must be 17 or 18 for the register map");
    end

    logic rst_meta_n;
    logic rst_n;
    pocr_pkg::pocr_bus_e bus_state;
    pocr_pkg::pocr_byte_t src_reg [2:4];
    pocr_pkg::pocr_byte_t charge_flags;
    pocr_pkg::pocr_byte_t gang_en;
    pocr_pkg::pocr_byte_t gang_sig;
    pocr_pkg::pocr_byte_t irq_status;
    pocr_pkg::pocr_byte_t irq_mask;
    logic [3:0] oc_prev;
    logic [3:0] oc_rise;
    logic [15:0] idx;
    logic aligned;
    logic wr_now;
    logic [7:0] wdata;
    pocr_pkg::pocr_byte_t next_rdata;
    logic [3:0] port_oc_sel;
    logic [15:0] gang_valid;
    wire logic [3:0] port_oc_now;

    // Reset release through two flops; asynchronous assert, clocked release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // Address decode: word index from byte address
    assign idx = 16'(avs_address[ADDR_W-1:2]);
    assign aligned = (avs_address[1:0] == 2'b00);
    assign wdata = avs_writedata[7:0];

    // One wait state: the first request cycle stalls, the second answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= pocr_pkg::POCR_BUS_IDLE;
        end else begin
            unique case (bus_state)
                pocr_pkg::POCR_BUS_IDLE: if (avs_read || avs_write) bus_state <= pocr_pkg::POCR_BUS_ANSWER;
                pocr_pkg::POCR_BUS_ANSWER: bus_state <= pocr_pkg::POCR_BUS_IDLE;
            endcase
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && (bus_state == pocr_pkg::POCR_BUS_IDLE);
    assign wr_now = avs_write && !avs_waitrequest && avs_byteenable[0] && aligned;

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (aligned) begin
            unique case (idx)
                `POCR_IDX_PORT2_SRC: next_rdata = src_reg[2];
                `POCR_IDX_PORT3_SRC: next_rdata = src_reg[3];
                `POCR_IDX_PORT4_SRC: next_rdata = src_reg[4];
                `POCR_IDX_CHARGE_FLAGS: next_rdata = charge_flags;
                `POCR_IDX_GANG_EN: next_rdata = gang_en;
                `POCR_IDX_GANG_SIG: next_rdata = gang_sig;
                `POCR_IDX_IRQ_STATUS: next_rdata = irq_status;
                `POCR_IDX_IRQ_MASK: next_rdata = irq_mask;
                `POCR_IDX_OC_LIVE: next_rdata = {4'h0, port_overcurrent};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data captured in the stall cycle so it stands when waitrequest drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // Source selectors; whole byte stored so reserved bits read back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_reg[2] <= `POCR_RST_SRC;
            src_reg[3] <= `POCR_RST_SRC;
            src_reg[4] <= `POCR_RST_SRC;
        end else if (wr_now) begin
            if (idx == `POCR_IDX_PORT2_SRC) src_reg[2] <= wdata;
            if (idx == `POCR_IDX_PORT3_SRC) src_reg[3] <= wdata;
            if (idx == `POCR_IDX_PORT4_SRC) src_reg[4] <= wdata;
        end
    end

    // Handshake flags: a detection wins over a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_flags <= `POCR_RST_CHARGE;
        end else if (wr_now && idx == `POCR_IDX_CHARGE_FLAGS) begin
            charge_flags <= wdata | {4'h0, charge_handshake_det};
        end else begin
            charge_flags <= charge_flags | {4'h0, charge_handshake_det};
        end
    end

    // Gang configuration; reserved bits kept but unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gang_en <= `POCR_RST_GANG_EN;
            gang_sig <= `POCR_RST_GANG_SIG;
        end else if (wr_now) begin
            if (idx == `POCR_IDX_GANG_EN) gang_en <= wdata;
            if (idx == `POCR_IDX_GANG_SIG) gang_sig <= wdata;
        end
    end

    // Port 1 selector lives elsewhere; its result arrives ready-made
    assign port_oc_now[0] = port1_overcurrent;
    for (genvar p = 2; p <= 4; p++) begin : g_port
        pocr_port_src u_src (
            .clk(clk),
            .rst_n(rst_n),
            .source_code(src_reg[p][`POCR_SRC_MSB:0]),
            .sense_pin(overcurrent_sense[p-1]),
            .gpio_pin(gpio_sense[p-1]),
            .overcurrent(port_oc_now[p-1])
        );
    end
    // Gathered on a net so every bit keeps a single driver
    assign port_overcurrent = port_oc_now;

    // Ganged status; an illegal code drives no pin rather than a guessed one
    assign port_oc_sel = port_overcurrent & gang_en[`POCR_GANG_EN_MSB:`POCR_GANG_EN_LSB];
    assign gang_valid = `POCR_GANG_VALID;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gang_overcurrent <= 1'b0;
            gang_pin_oe <= 16'h0000;
        end else begin
            gang_overcurrent <= |port_oc_sel;
            if (gang_sig[`POCR_GANG_SIG_MSB:4] == 2'b00 && gang_valid[gang_sig[3:0]]) begin
                gang_pin_oe <= 16'h0001 << gang_sig[3:0];
            end else begin
                gang_pin_oe <= 16'h0000;
            end
        end
    end

    // Interrupt: sticky on over-current onset, write one to clear, set wins
    assign oc_rise = port_overcurrent & ~oc_prev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_prev <= 4'h0;
            irq_status <= `POCR_RST_IRQ;
            irq_mask <= `POCR_RST_IRQ;
        end else begin
            oc_prev <= port_overcurrent;
            if (wr_now && idx == `POCR_IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~wdata) | {4'h0, oc_rise};
            end else begin
                irq_status <= irq_status | {4'h0, oc_rise};
            end
            if (wr_now && idx == `POCR_IDX_IRQ_MASK) irq_mask <= wdata & 8'h0f;
        end
    end
    assign irq = |(irq_status & irq_mask);

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
        |charge_handshake_det |=> (charge_flags[3:0] & $past(charge_handshake_det)) == $past(charge_handshake_det);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("handshake flag not set");

    property p_gang;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> gang_overcurrent == $past(|(port_overcurrent & gang_en[4:1]));
    endproperty
    a_gang: assert property (p_gang) else $error("gang status wrong");

    property p_gang_pin;
        @(posedge clk) disable iff (!rst_n)
        $onehot0(gang_pin_oe) && (gang_pin_oe & ~`POCR_GANG_VALID) == 16'h0000;
    endproperty
    a_gang_pin: assert property (p_gang_pin) else $error("gang pin on illegal code");

    property p_gang_code;
        @(posedge clk) disable iff (!rst_n)
        gang_sig == 8'h0f |=> gang_pin_oe == 16'h8000;
    endproperty
    a_gang_code: assert property (p_gang_code) else $error("code 15 not routed");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        wr_now && idx == `POCR_IDX_GANG_EN |=> gang_en == $past(wdata);
    endproperty
    a_reserved: assert property (p_reserved) else $error("write not stored whole");

    property p_wait;
        @(posedge clk) disable iff (!rst_n)
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait longer than one cycle");

    property p_irq_rise;
        @(posedge clk) disable iff (!rst_n)
        $rose(port_overcurrent[1]) |=> irq_status[1];
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("onset not latched");

    property p_cov_gang;
        @(posedge clk) disable iff (!rst_n)
        gang_overcurrent && |gang_pin_oe;
    endproperty
    c_cov_gang: cover property (p_cov_gang);

    property p_cov_irq;
        @(posedge clk) disable iff (!rst_n)
        irq ##1 !irq;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_gang_off;
        @(posedge clk) disable iff (!rst_n)
        gang_sig[`POCR_GANG_SIG_MSB:4] != 2'b00 |=> gang_pin_oe == 16'h0000;
    endproperty
    a_gang_off: assert property (p_gang_off) else $error("gang pin on for a code above 15");

    property p_gang_gap;
        @(posedge clk) disable iff (!rst_n)
        gang_sig[`POCR_GANG_SIG_MSB:0] == 6'h02 |=> gang_pin_oe == 16'h0000;
    endproperty
    a_gang_gap: assert property (p_gang_gap) else $error("gang pin on for code 2");

    property p_src_store;
        @(posedge clk) disable iff (!rst_n)
        wr_now && idx == `POCR_IDX_PORT3_SRC |=> src_reg[3] == $past(wdata);
    endproperty
    a_src_store: assert property (p_src_store) else $error("selector byte not stored whole");

    property p_flag_write;
        @(posedge clk) disable iff (!rst_n)
        wr_now && idx == `POCR_IDX_CHARGE_FLAGS
            |=> charge_flags == ($past(wdata) | {4'h0, $past(charge_handshake_det)});
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("handshake flag write wrong");

    property p_w1c;
        @(posedge clk) disable iff (!rst_n)
        wr_now && idx == `POCR_IDX_IRQ_STATUS && oc_rise == 4'h0 |=> (irq_status & $past(wdata)) == 8'h00;
    endproperty
    a_w1c: assert property (p_w1c) else $error("status bit survived a write of one");

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        |oc_rise |=> (irq_status[3:0] & $past(oc_rise)) == $past(oc_rise);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("onset lost to a clear");

    property p_mask_upper;
        @(posedge clk) disable iff (!rst_n)
        irq_mask[7:4] == 4'h0;
    endproperty
    a_mask_upper: assert property (p_mask_upper) else $error("mask upper bits not zero");

    property p_read_upper;
        @(posedge clk) disable iff (!rst_n)
        avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("read data upper lanes not zero");

    property p_read_answer;
        @(posedge clk) disable iff (!rst_n)
        avs_read && avs_waitrequest && aligned && idx == `POCR_IDX_GANG_SIG
            |=> avs_readdata[7:0] == $past(gang_sig);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data not captured in stall cycle");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        avs_write && (!aligned || !avs_byteenable[0]) |=> $stable(gang_en) && $stable(gang_sig);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("refused write changed a register");

    property p_cov_w1c;
        @(posedge clk) disable iff (!rst_n)
        wr_now && idx == `POCR_IDX_IRQ_STATUS && |irq_status;
    endproperty
    c_cov_w1c: cover property (p_cov_w1c);

    property p_cov_charge;
        @(posedge clk) disable iff (!rst_n)
        |charge_handshake_det ##1 |charge_flags[3:0];
    endproperty
    c_cov_charge: cover property (p_cov_charge);
endmodule

// ### rtl/pocr_regs.svh
// Offsets, field positions, reset values and codes of the over-current routing bank.
// Assumes the includer works on byte addresses four times the register index.
// Operation
// - Each port has a 4-bit source selector in bits 3:0; code 0000b disables it.
// - Selector 0001b takes over-current from the port's dedicated sense pin.
// - Selector 0010b takes over-current from a general-purpose input pin.
// - Selector 1111b forces the port's over-current on for test.
// - One charging-handshake flag per port, port 4 bit 3 to port 1 bit 0.
// - Gang enables in bits 4:1 route each port's over-current onto the gang signal.
// - Six-bit gang signal code accepts only 0,1,3-11 and 15.
`ifndef POCR_REGS_SVH
`define POCR_REGS_SVH

// Register indices; byte address is four times the index
`define POCR_IDX_PORT2_SRC 16'h3c24
`define POCR_IDX_PORT3_SRC 16'h3c28
`define POCR_IDX_PORT4_SRC 16'h3c2c
`define POCR_IDX_CHARGE_FLAGS 16'h5246
`define POCR_IDX_GANG_EN 16'h525a
`define POCR_IDX_GANG_SIG 16'h525b
`define POCR_IDX_IRQ_STATUS 16'h5260
`define POCR_IDX_IRQ_MASK 16'h5261
`define POCR_IDX_OC_LIVE 16'h5262

// Reset values
`define POCR_RST_SRC 8'h00
`define POCR_RST_CHARGE 8'h00
`define POCR_RST_GANG_EN 8'h00
`define POCR_RST_GANG_SIG 8'h00
`define POCR_RST_IRQ 8'h00

// Field positions
`define POCR_SRC_MSB 3
`define POCR_GANG_EN_LSB 1
`define POCR_GANG_EN_MSB 4
`define POCR_GANG_SIG_MSB 5

// Source selector codes
`define POCR_SRC_OFF 4'h0
`define POCR_SRC_PIN 4'h1
`define POCR_SRC_GPIO 4'h2
`define POCR_SRC_FORCE 4'hf

// Gang signal codes that may drive a pin (bit n set when code n is legal)
`define POCR_GANG_VALID 16'h8ffb

// Bus answer latency in wait-state cycles
`define POCR_WAIT_CYCLES 1

`endif

// ### rtl/pocr_pkg.sv
// Types shared by the over-current routing bank.
// Assumes pocr_regs.svh carries all numeric constants.
package pocr_pkg;
    typedef logic [7:0] pocr_byte_t;
    typedef enum logic {POCR_BUS_IDLE, POCR_BUS_ANSWER} pocr_bus_e;
endpackage

// ### rtl/pocr_port_src.sv
// One downstream port's over-current source selection.
// Assumes sense and gpio inputs are synchronous to clk and active high.
`timescale 1ns/1ps
`include "pocr_regs.svh"
module pocr_port_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] source_code,
    input wire logic sense_pin,
    input wire logic gpio_pin,
    output logic overcurrent
);
    // Selected over-current level, registered; reserved codes read as no fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent <= 1'b0;
        end else begin
            case (source_code)
                `POCR_SRC_OFF: overcurrent <= 1'b0;
                `POCR_SRC_PIN: overcurrent <= sense_pin;
                `POCR_SRC_GPIO: overcurrent <= gpio_pin;
                `POCR_SRC_FORCE: overcurrent <= 1'b1;
                default: overcurrent <= 1'b0;
            endcase
        end
    end

    property p_src_off;
        @(posedge clk) disable iff (!rst_n)
        source_code == `POCR_SRC_OFF |=> !overcurrent;
    endproperty
    a_src_off: assert property (p_src_off) else $error("disabled port shows over-current");

    property p_src_pin;
        @(posedge clk) disable iff (!rst_n)
        source_code == `POCR_SRC_PIN |=> overcurrent == $past(sense_pin);
    endproperty
    a_src_pin: assert property (p_src_pin) else $error("sense pin not followed");

    property p_src_gpio;
        @(posedge clk) disable iff (!rst_n)
        source_code == `POCR_SRC_GPIO |=> overcurrent == $past(gpio_pin);
    endproperty
    a_src_gpio: assert property (p_src_gpio) else $error("gpio source not followed");

    property p_src_force;
        @(posedge clk) disable iff (!rst_n)
        (source_code == `POCR_SRC_FORCE) [*2] |-> overcurrent;
    endproperty
    a_src_force: assert property (p_src_force) else $error("forced over-current missing");

    property p_cov_force;
        @(posedge clk) disable iff (!rst_n)
        source_code == `POCR_SRC_FORCE ##1 overcurrent;
    endproperty
    c_cov_force: cover property (p_cov_force);
endmodule

// ### dv/pocr_switch_model.sv
// Model of the port power switches that feed the over-current sense inputs.
// Assumes the bench commands trips at the rising edge of clk.
`timescale 1ns/1ps
module pocr_switch_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] trip,
    input wire logic [3:0] gpio_trip,
    output logic [3:0] sense,
    output logic [3:0] gpio
);
    // Flags settle one cycle after the load fault, as a current limiter would
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sense <= 4'h0;
            gpio <= 4'h0;
        end else begin
            sense <= trip;
            gpio <= gpio_trip;
        end
    end
endmodule

// ### dv/pocr_top_bench.sv
// Self-checking bench for the over-current routing bank.
// Assumes one wait state per bus request and the switch model on the sense pins.
`timescale 1ns/1ps
module pocr_top_bench;
    logic clk, nrst, avs_read, avs_write, port1_overcurrent, gang_overcurrent, irq, avs_waitrequest;
    logic [16:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] trip, gpio_trip, overcurrent_sense, gpio_sense, charge_handshake_det, port_overcurrent;
    logic [3:0] avs_byteenable;
    logic [15:0] gang_pin_oe;
    logic [7:0] rd;
    int err_total, compares, cyc;

    pocr_switch_model sw (.clk(clk), .nrst(nrst), .trip(trip), .gpio_trip(gpio_trip),
        .sense(overcurrent_sense), .gpio(gpio_sense));
    pocr_top #(.ADDR_W(17)) dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .overcurrent_sense(overcurrent_sense),
        .gpio_sense(gpio_sense), .port1_overcurrent(port1_overcurrent), .charge_handshake_det(charge_handshake_det),
        .port_overcurrent(port_overcurrent), .gang_overcurrent(gang_overcurrent), .gang_pin_oe(gang_pin_oe),
        .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cut a hang short well beyond the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low, released right after that edge; only the timeout ends a hang
    task automatic bus(input logic wr, input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset();
        logic [16:0] adr [7] = '{17'h0f090, 17'h0f0a0, 17'h0f0b0, 17'h14918, 17'h14968, 17'h1496c, 17'h00100};
        bus(1'b1, 17'h00100, 8'h5a, rd);
        // Lane-off and misaligned writes must be refused; the reads below judge them
        avs_byteenable <= 4'h0;
        bus(1'b1, 17'h1496c, 8'h0b, rd);
        avs_byteenable <= 4'h1;
        bus(1'b1, 17'h1496d, 8'h0b, rd);
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 8'h00, rd);
            check(rd, 8'h00);
        end
        bus(1'b1, 17'h14968, 8'he1, rd);
        bus(1'b0, 17'h14968, 8'h00, rd);
        check(rd, 8'he1);
    endtask

    task automatic t_charge();
        charge_handshake_det <= 4'h9;
        tick(1);
        charge_handshake_det <= 4'h0;
        bus(1'b0, 17'h14918, 8'h00, rd);
        check(rd, 8'h09);
        bus(1'b1, 17'h14918, 8'ha0, rd);
        bus(1'b0, 17'h14918, 8'h00, rd);
        check(rd, 8'ha0);
    endtask

    task automatic t_sources();
        logic [3:0] code [6] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'hf};
        logic [2:0] sgx [6] = '{3'b110, 3'b101, 3'b010, 3'b011, 3'b100, 3'b001};
        for (int p = 1; p < 4; p++) begin
            for (int i = 0; i < 6; i++) begin
                bus(1'b1, 17'h0f080 + 17'(16 * p), {4'h0, code[i]}, rd); // Only defined codes
                trip <= {4{sgx[i][2]}};
                gpio_trip <= {4{sgx[i][1]}};
                tick(4);
                check(port_overcurrent[p], sgx[i][0]);
            end
        end
    endtask

    task automatic t_gang();
        bus(1'b1, 17'h14968, 8'h04, rd);
        tick(3);
        check(gang_overcurrent, 1'b1);
        bus(1'b1, 17'h14968, 8'h02, rd);
        tick(3);
        check(gang_overcurrent, 1'b0);
        port1_overcurrent <= 1'b1;
        tick(1);
        check(port_overcurrent[0], 1'b1);
        tick(2);
        check(gang_overcurrent, 1'b1);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, 17'h1496c, {2'b11, 6'(c)}, rd);
            tick(1);
            check(gang_pin_oe, ((c != 2 && c < 12) || c == 15) ? 16'h1 << c : 16'h0);
        end
        bus(1'b1, 17'h1496c, 8'h3f, rd);
        tick(1);
        check(gang_pin_oe, 16'h0);
    endtask

    task automatic t_irq();
        trip <= 4'h0;
        gpio_trip <= 4'h0;
        bus(1'b1, 17'h0f090, 8'h00, rd);
        bus(1'b1, 17'h0f0a0, 8'h01, rd);
        bus(1'b1, 17'h0f0b0, 8'h00, rd);
        bus(1'b1, 17'h14980, 8'h0f, rd);
        bus(1'b1, 17'h14984, 8'h00, rd);
        trip <= 4'h4;
        tick(4);
        bus(1'b0, 17'h14980, 8'h00, rd);
        check(rd, 8'h04);
        bus(1'b0, 17'h14988, 8'h00, rd);
        check(rd, 8'h05);
        check(irq, 1'b0);
        bus(1'b1, 17'h14984, 8'h04, rd);
        check(irq, 1'b1);
        bus(1'b1, 17'h14980, 8'h04, rd);
        check(irq, 1'b0);
        bus(1'b0, 17'h14980, 8'h00, rd);
        check(rd, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Inputs settle at time zero; reset held 20 cycles, first request at the third edge
    initial begin
        nrst = 1'b0;
        avs_address = 17'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        trip = 4'h0;
        gpio_trip = 4'h0;
        port1_overcurrent = 1'b0;
        charge_handshake_det = 4'h0;
        tick(20);
        nrst <= 1'b1;
        tick(3);
        t_reset();
        t_charge();
        t_sources();
        t_gang();
        t_irq();
        tally_and_finish();
    end
endmodule
